//--- dma_ctrl_pkg.sv
// Package with register map, field positions and carrier types of the DMA enable control
package dma_ctrl_pkg;

    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CH1_STAT = 8'h10;

    // Control word: high byte in bits 15:8, low byte in bits 7:0
    localparam int B_FAE1         = 15;
    localparam int B_FAE0         = 14;
    localparam int B_CH1_AUTO     = 11;
    localparam int B_CH0_AUTO     = 9;
    localparam int B_RSVD8        = 8;
    localparam int B_CH1_ME       = 7;
    localparam int B_CH1_TE       = 6;
    localparam int B_CH0_ME       = 5;
    localparam int B_CH0_TE       = 4;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    localparam int IRQ_W        = 3;
    localparam int IRQ_CH0_ACK  = 0;
    localparam int IRQ_CH1_SUSP = 1;
    localparam int IRQ_CH1_END  = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    localparam int B_ST_BUSY  = 0;
    localparam int B_ST_SUSP  = 1;
    localparam int B_ST_ARMED = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } reg_wr_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
    } reg_rd_t;

    typedef struct packed {
        logic              aw_full;
        logic              w_full;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } axil_state_t;

    typedef struct packed {
        logic [IRQ_W-1:0] stat;
        logic [IRQ_W-1:0] en;
    } irq_state_t;

    typedef enum logic [1:0] {CH1_IDLE, CH1_XFER, CH1_SUSP} ch1_state_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic        armed;
        ch1_state_t  ch1;
        logic        ch0_clear;
        logic        ch0_irq;
    } main_state_t;

endpackage

//--- axil_reg_slave.sv
// AXI4-Lite slave that turns bus accesses into register strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave
    import dma_ctrl_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output reg_wr_t                wr_o,
    input  wire logic              wr_err_i,
    output reg_rd_t                rd_o,
    input  wire logic [31:0]       rd_data_i,
    input  wire logic              rd_err_i
);
    axil_state_t r;
    axil_state_t n;

    assign s_axi_awready_o = !r.aw_full;
    assign s_axi_wready_o  = !r.w_full;
    assign s_axi_arready_o = !r.rvalid;
    assign s_axi_bvalid_o  = r.bvalid;
    assign s_axi_bresp_o   = r.bresp;
    assign s_axi_rvalid_o  = r.rvalid;
    assign s_axi_rdata_o   = r.rdata;
    assign s_axi_rresp_o   = r.rresp;

    always_comb begin
        n = r;
        wr_o.en   = r.aw_full && r.w_full && !r.bvalid;
        wr_o.addr = r.awaddr;
        wr_o.data = r.wdata;
        wr_o.strb = r.wstrb;
        rd_o.en   = s_axi_arvalid_i && !r.rvalid;
        rd_o.addr = s_axi_araddr_i;
        if (s_axi_awvalid_i && !r.aw_full) begin
            n.aw_full = 1'b1;
            n.awaddr  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !r.w_full) begin
            n.w_full = 1'b1;
            n.wdata  = s_axi_wdata_i;
            n.wstrb  = s_axi_wstrb_i;
        end
        if (r.bvalid && s_axi_bready_i) begin
            n.bvalid = 1'b0;
        end
        if (wr_o.en) begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = wr_err_i ? RESP_SLVERR : RESP_OKAY;
        end
        if (r.rvalid && s_axi_rready_i) begin
            n.rvalid = 1'b0;
        end
        if (rd_o.en) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_data_i;
            n.rresp  = rd_err_i ? RESP_SLVERR : RESP_OKAY;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

//--- irq_sticky.sv
// Sticky event status with enable mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module irq_sticky
    import dma_ctrl_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [IRQ_W-1:0] set_i,
    input  wire logic             clr_wr_i,
    input  wire logic             en_wr_i,
    input  wire logic [IRQ_W-1:0] wdata_i,
    output logic      [IRQ_W-1:0] stat_o,
    output logic      [IRQ_W-1:0] en_o,
    output logic                  irq_o
);
    irq_state_t r;
    irq_state_t n;

    assign stat_o = r.stat;
    assign en_o   = r.en;
    assign irq_o  = |(r.stat & r.en);

    always_comb begin
        n = r;
        // Set wins over a clear in the same cycle
        n.stat = (r.stat & ~(clr_wr_i ? wdata_i : IRQ_RST)) | set_i;
        if (en_wr_i) begin
            n.en = wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

//--- dma_channel_enable_ack_ctrl.sv
// Channel enable, interrupt acknowledge and NMI suspend control of a two-channel DMA
//
// Summary of operation
// - Ch0 enabled with auto-clear: clear source, block request
// - Ch0 enabled without auto-clear: source stays, request passes
// - Ch0 transfer disabled: request always passes
// - Ch0 master enable has no effect here
// - Reserved bit 8 stores writes; write zero
// - Ch1 moves only with both enables set
// - Burst NMI clears ch1 master enable, halts
// - Setting master enable again resumes transfer
// - Block mode ignores NMI entirely
// - Ch1 master enable: reset, burst NMI, write zero
// - Ch1 master enable set needs prior zero read
// - Sub-channels A and B act as one
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_enable_ack_ctrl
    import dma_ctrl_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              ch0_src_irq_i,
    input  wire logic              ch0_xfer_ack_i,
    output logic                   ch0_src_clear_o,
    output logic                   ch0_irq_req_o,
    input  wire logic              ch1_req_i,
    input  wire logic              ch1_burst_mode_i,
    input  wire logic              ch1_xfer_end_i,
    input  wire logic              nmi_i,
    output logic                   ch1_xfer_en_o,
    output logic                   ch1_bus_req_o,
    output logic                   irq_o
);
    main_state_t      r;
    main_state_t      n;
    reg_wr_t          wr;
    reg_rd_t          rd;
    logic [31:0]      rd_data;
    logic             rd_err;
    logic             wr_err;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic             ch0_auto;
    logic             ch1_en;
    logic             nmi_burst;
    logic             ctrl_wr;
    logic             ctrl_lo_wr;
    logic             irq_clr_wr;
    logic             irq_en_wr;

    axil_reg_slave u_bus (
        .sys_clk_i       (sys_clk_i),
        .sys_rst_i       (sys_rst_i),
        .s_axi_awaddr_i  (s_axi_awaddr_i),
        .s_axi_awvalid_i (s_axi_awvalid_i),
        .s_axi_awready_o (s_axi_awready_o),
        .s_axi_wdata_i   (s_axi_wdata_i),
        .s_axi_wstrb_i   (s_axi_wstrb_i),
        .s_axi_wvalid_i  (s_axi_wvalid_i),
        .s_axi_wready_o  (s_axi_wready_o),
        .s_axi_bresp_o   (s_axi_bresp_o),
        .s_axi_bvalid_o  (s_axi_bvalid_o),
        .s_axi_bready_i  (s_axi_bready_i),
        .s_axi_araddr_i  (s_axi_araddr_i),
        .s_axi_arvalid_i (s_axi_arvalid_i),
        .s_axi_arready_o (s_axi_arready_o),
        .s_axi_rdata_o   (s_axi_rdata_o),
        .s_axi_rresp_o   (s_axi_rresp_o),
        .s_axi_rvalid_o  (s_axi_rvalid_o),
        .s_axi_rready_i  (s_axi_rready_i),
        .wr_o            (wr),
        .wr_err_i        (wr_err),
        .rd_o            (rd),
        .rd_data_i       (rd_data),
        .rd_err_i        (rd_err)
    );

    irq_sticky u_irq (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (irq_set),
        .clr_wr_i  (irq_clr_wr),
        .en_wr_i   (irq_en_wr),
        .wdata_i   (wr.data[IRQ_W-1:0]),
        .stat_o    (irq_stat),
        .en_o      (irq_en),
        .irq_o     (irq_o)
    );

    assign ch0_src_clear_o = r.ch0_clear;
    assign ch0_irq_req_o   = r.ch0_irq;
    assign ch1_en          = r.ctrl[B_CH1_ME] && r.ctrl[B_CH1_TE];
    assign ch1_xfer_en_o   = ch1_en;
    assign ch1_bus_req_o   = (r.ch1 == CH1_XFER) && ch1_en;
    assign ch0_auto        = r.ctrl[B_CH0_TE] && r.ctrl[B_CH0_AUTO];
    assign nmi_burst       = nmi_i && ch1_burst_mode_i;
    assign ctrl_wr         = wr.en && wr.addr == OFF_CTRL;
    assign ctrl_lo_wr      = ctrl_wr && wr.strb[0];
    assign irq_clr_wr      = wr.en && wr.addr == OFF_IRQ_CLR;
    assign irq_en_wr       = wr.en && wr.addr == OFF_IRQ_EN;

    // Read decode and unmapped answer
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (rd.addr)
            OFF_CTRL: begin
                rd_data[15:0] = r.ctrl;
            end
            OFF_IRQ_STAT: begin
                rd_data[IRQ_W-1:0] = irq_stat;
            end
            OFF_IRQ_CLR: begin
                rd_data = 32'h0000_0000;
            end
            OFF_IRQ_EN: begin
                rd_data[IRQ_W-1:0] = irq_en;
            end
            OFF_CH1_STAT: begin
                rd_data[B_ST_BUSY]  = r.ch1 == CH1_XFER;
                rd_data[B_ST_SUSP]  = r.ch1 == CH1_SUSP;
                rd_data[B_ST_ARMED] = r.armed;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    always_comb begin
        case (wr.addr)
            OFF_CTRL, OFF_IRQ_STAT, OFF_IRQ_CLR, OFF_IRQ_EN, OFF_CH1_STAT: begin
                wr_err = 1'b0;
            end
            default: begin
                wr_err = 1'b1;
            end
        endcase
    end

    always_comb begin
        n = r;
        irq_set = IRQ_RST;

        if (ctrl_wr && wr.strb[1]) begin
            n.ctrl[15:8] = wr.data[15:8];
        end
        if (ctrl_lo_wr) begin
            n.ctrl[B_CH1_ME-1:0] = wr.data[B_CH1_ME-1:0];
            if (!wr.data[B_CH1_ME]) begin
                n.ctrl[B_CH1_ME] = 1'b0;
            end else if (r.armed) begin
                n.ctrl[B_CH1_ME] = 1'b1;
            end
            n.armed = 1'b0;
        end

        if (rd.en && rd.addr == OFF_CTRL && !r.ctrl[B_CH1_ME]) begin
            n.armed = 1'b1;
        end

        if (nmi_burst) begin
            n.ctrl[B_CH1_ME] = 1'b0;
        end

        n.ch0_clear = ch0_xfer_ack_i && ch0_auto;
        n.ch0_irq = ch0_src_irq_i && !ch0_auto;
        if (n.ch0_clear) begin
            irq_set[IRQ_CH0_ACK] = 1'b1;
        end

        case (r.ch1)
            CH1_IDLE: begin
                if (ch1_en && ch1_req_i && !nmi_burst) begin
                    n.ch1 = CH1_XFER;
                end
            end

            CH1_XFER: begin
                if (nmi_burst) begin
                    n.ch1 = CH1_SUSP;
                    irq_set[IRQ_CH1_SUSP] = 1'b1;
                end else if (!r.ctrl[B_CH1_TE]) begin
                    n.ch1 = CH1_IDLE;
                end else if (!r.ctrl[B_CH1_ME]) begin
                    n.ch1 = CH1_SUSP;
                end else if (ch1_xfer_end_i) begin
                    n.ch1 = CH1_IDLE;
                    irq_set[IRQ_CH1_END] = 1'b1;
                end
            end

            CH1_SUSP: begin
                if (!r.ctrl[B_CH1_TE]) begin
                    n.ch1 = CH1_IDLE;
                end else if (r.ctrl[B_CH1_ME]) begin
                    n.ch1 = CH1_XFER;
                end
            end

            default: begin
                n.ch1 = CH1_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r.ctrl      <= CTRL_RST;
            r.armed     <= 1'b0;
            r.ch1       <= CH1_IDLE;
            r.ch0_clear <= 1'b0;
            r.ch0_irq   <= 1'b0;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_CH0_AUTO_CLEAR: assert property (
        ch0_xfer_ack_i && r.ctrl[B_CH0_TE] && r.ctrl[B_CH0_AUTO] && !ctrl_wr
        |=> ch0_src_clear_o && irq_stat[IRQ_CH0_ACK])
        else $error("Source not cleared on auto-clear transfer");

    AST_CH0_NO_CLEAR: assert property (
        ch0_xfer_ack_i && ch0_src_irq_i && r.ctrl[B_CH0_TE] && !r.ctrl[B_CH0_AUTO]
        && !ctrl_wr |=> !ch0_src_clear_o && ch0_irq_req_o)
        else $error("Source cleared or request blocked without auto-clear");

    AST_CH0_DISABLED_PASS: assert property (
        ch0_src_irq_i && !r.ctrl[B_CH0_TE] && !ctrl_wr |=> ch0_irq_req_o)
        else $error("Request blocked while ch0 transfer disabled");

    AST_CH0_ME_IGNORED: assert property (
        ch0_src_irq_i && ch0_auto && !r.ctrl[B_CH0_ME] && !ctrl_wr
        |=> !ch0_irq_req_o)
        else $error("Ch0 master enable changed forwarding");

    AST_RSVD8_RW: assert property (
        ctrl_wr && wr.strb[1] |=> r.ctrl[B_RSVD8] == $past(wr.data[B_RSVD8]))
        else $error("Reserved bit 8 did not store write");

    AST_CH1_ENABLE_DROP: assert property (
        r.ch1 == CH1_XFER && !ch1_en |=> r.ch1 != CH1_XFER)
        else $error("Ch1 kept transferring without both enables");

    AST_NMI_BURST_SUSPEND: assert property (
        nmi_burst && r.ch1 == CH1_XFER
        |=> r.ch1 == CH1_SUSP && !r.ctrl[B_CH1_ME] && !ch1_bus_req_o)
        else $error("Burst NMI did not suspend ch1");

    AST_RESUME: assert property (
        r.ch1 == CH1_SUSP && ch1_en |=> r.ch1 == CH1_XFER)
        else $error("Suspended ch1 did not resume");

    AST_NMI_BLOCK_IGNORED: assert property (
        nmi_i && !ch1_burst_mode_i && r.ch1 == CH1_XFER && ch1_en && !ch1_xfer_end_i
        && !ctrl_wr |=> r.ch1 == CH1_XFER && r.ctrl[B_CH1_ME])
        else $error("Block-mode NMI disturbed ch1");

    AST_ME_CLEAR: assert property (
        nmi_burst || ctrl_lo_wr && !wr.data[B_CH1_ME] |=> !r.ctrl[B_CH1_ME])
        else $error("Ch1 master enable not cleared");

    AST_ME_SET_AFTER_READ: assert property (
        $rose(r.ctrl[B_CH1_ME]) |-> $past(ctrl_lo_wr) && $past(r.armed))
        else $error("Ch1 master enable set without prior zero read");

    AST_CH0_CLEAR_PULSE: assert property (
        ch0_src_clear_o && !ch0_xfer_ack_i
        |=> !ch0_src_clear_o)
        else $error("Source clear longer than one transfer");

    AST_CH1_IDLE_HOLD: assert property (
        r.ch1 == CH1_IDLE && !ch1_en
        |=> r.ch1 == CH1_IDLE && !ch1_bus_req_o)
        else $error("Ch1 started without both enables");

    AST_NMI_SUSP_FLAG: assert property (
        nmi_burst && r.ch1 == CH1_XFER
        |=> irq_stat[IRQ_CH1_SUSP])
        else $error("Burst NMI suspend not flagged");

    AST_BLOCK_NMI_KEEPS_ME: assert property (
        nmi_i && !ch1_burst_mode_i && r.ctrl[B_CH1_ME] && !ctrl_lo_wr
        |=> r.ctrl[B_CH1_ME])
        else $error("Block-mode NMI cleared ch1 master enable");

    AST_ARM_ON_READ: assert property (
        rd.en && rd.addr == OFF_CTRL && !r.ctrl[B_CH1_ME]
        |=> r.armed)
        else $error("Zero read of ctrl did not arm master enable set");

    AST_ME_NO_SET_UNARMED: assert property (
        ctrl_lo_wr && wr.data[B_CH1_ME] && !r.armed && !r.ctrl[B_CH1_ME]
        |=> !r.ctrl[B_CH1_ME])
        else $error("Ch1 master enable set without arming");

    COV_AUTO_CLEAR: cover property (ch0_src_clear_o);
    COV_SUSPEND_RESUME: cover property (
        r.ch1 == CH1_SUSP ##[1:50] r.ch1 == CH1_XFER);
    COV_BLOCK_NMI: cover property (
        nmi_i && !ch1_burst_mode_i && r.ch1 == CH1_XFER);
    COV_IRQ: cover property (irq_o);
    COV_CH1_ME_DROP: cover property (r.ch1 == CH1_XFER && !ch1_en);
endmodule
`default_nettype wire

//--- irq_source_model.sv
// Model of the interrupt source and of the CPU side that services it
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic raise_i,
    input  wire logic src_clear_i,
    input  wire logic irq_req_i,
    input  wire logic cpu_service_i,
    output logic      src_irq_o
);
    logic [1:0] svc_cnt_r;
    logic       svc_go;

    assign svc_go = cpu_service_i && irq_req_i && (svc_cnt_r != 2'h2);

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            src_irq_o <= 1'b0;
            svc_cnt_r <= 2'h0;
        end else begin
            // Source drops on auto clear or CPU service
            if (raise_i) begin
                src_irq_o <= 1'b1;
            end else if (src_clear_i || svc_cnt_r == 2'h2) begin
                src_irq_o <= 1'b0;
            end
            svc_cnt_r <= svc_go ? svc_cnt_r + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

//--- dma_channel_enable_ack_ctrl_tb.sv
// Self-checking bench for the DMA channel enable and acknowledge control
`timescale 1ns/1ps
`default_nettype none
module dma_channel_enable_ack_ctrl_tb;
    import dma_ctrl_pkg::*;
    logic              sys_clk, sys_rst;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, got;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, resp;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic              src_irq, ack, src_clr, irq_req, ch1_req, burst, xfer_end, nmi;
    logic              xfer_en, bus_req, irq, raise, service;
    int                mismatches, tests_run, base;
    int                clr_cnt = 0;
    logic [15:0]       c0_ctrl [4] = '{16'h0210, 16'h0230, 16'h0010, 16'h0200};
    logic              c0_clr  [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

    dma_channel_enable_ack_ctrl i_dut (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .ch0_src_irq_i(src_irq), .ch0_xfer_ack_i(ack), .ch0_src_clear_o(src_clr),
        .ch0_irq_req_o(irq_req), .ch1_req_i(ch1_req), .ch1_burst_mode_i(burst),
        .ch1_xfer_end_i(xfer_end), .nmi_i(nmi), .ch1_xfer_en_o(xfer_en),
        .ch1_bus_req_o(bus_req), .irq_o(irq)
    );

    irq_source_model i_src (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .raise_i(raise), .src_clear_i(src_clr),
        .irq_req_i(irq_req), .cpu_service_i(service), .src_irq_o(src_irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        if (src_clr === 1'b1) clr_cnt <= clr_cnt + 1;
    end

    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk1(input string what, input logic seen, input logic exp);
        chk(what, {31'h0, seen}, {31'h0, exp});
    endtask

    task automatic step(inout int n);
        n++;
        if (n > 50) begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hit, w_hit, hit;
        int   n;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            @(posedge sys_clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            step(n);
        end while ((awvalid && !aw_hit) || (wvalid && !w_hit));
        n = 0;
        do begin
            @(negedge sys_clk);
            hit = bvalid;
            resp = bresp;
            @(posedge sys_clk);
            step(n);
        end while (!hit);
        bready <= 1'b0;
        chk($sformatf("bresp %h", a), {30'h0, resp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic hit;
        int   n;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            hit = arready;
            @(posedge sys_clk);
            step(n);
        end while (!hit);
        arvalid <= 1'b0;
        n = 0;
        do begin
            @(negedge sys_clk);
            hit = rvalid;
            got = rdata;
            resp = rresp;
            @(posedge sys_clk);
            step(n);
        end while (!hit);
        rready <= 1'b0;
        chk($sformatf("rdata %h", a), got, exp);
        chk($sformatf("rresp %h", a), {30'h0, resp}, {30'h0, er});
    endtask

    initial begin
        sys_rst = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {ack, ch1_req, burst, xfer_end, nmi, raise, service} = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(OFF_CH1_STAT, 32'h0, RESP_OKAY);
        rd(OFF_CTRL, {16'h0, CTRL_RST}, RESP_OKAY);
        rd(OFF_IRQ_EN, 32'h0, RESP_OKAY);
        rd(OFF_IRQ_CLR, 32'h0, RESP_OKAY);
        rd(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h1, RESP_SLVERR);
        wr(OFF_IRQ_STAT, 32'h7, RESP_OKAY);
        rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
        wr(OFF_CTRL, 32'hABCD0100, RESP_OKAY);
        rd(OFF_CTRL, 32'h00000100, RESP_OKAY);
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CTRL, {16'h0, c0_ctrl[i]}, RESP_OKAY);
            base = clr_cnt;
            @(posedge sys_clk);
            raise <= 1'b1;
            @(posedge sys_clk);
            raise <= 1'b0;
            settle(2);
            chk1("ch0 irq_req", irq_req, !c0_clr[i]);
            @(posedge sys_clk);
            ack <= 1'b1;
            @(posedge sys_clk);
            ack <= 1'b0;
            settle(3);
            chk("ch0 clear pulses", 32'(clr_cnt - base), {31'h0, c0_clr[i]});
            chk1("ch0 source", src_irq, !c0_clr[i]);
            @(posedge sys_clk);
            service <= 1'b1;
            settle(5);
            chk1("ch0 serviced", irq_req, 1'b0);
            @(posedge sys_clk);
            service <= 1'b0;
        end
        rd(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
        wr(OFF_IRQ_CLR, 32'h1, RESP_OKAY);
        rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
        wr(OFF_CTRL, 32'h000000C0, RESP_OKAY);
        settle(1);
        chk1("ch1 xfer_en unarmed", xfer_en, 1'b0);
        rd(OFF_CTRL, 32'h00000040, RESP_OKAY);
        wr(OFF_CTRL, 32'h000000C0, RESP_OKAY);
        @(posedge sys_clk);
        burst <= 1'b1;
        ch1_req <= 1'b1;
        settle(3);
        chk1("ch1 xfer_en", xfer_en, 1'b1);
        chk1("ch1 bus_req", bus_req, 1'b1);
        @(posedge sys_clk);
        nmi <= 1'b1;
        @(posedge sys_clk);
        nmi <= 1'b0;
        settle(2);
        chk1("ch1 bus_req burst nmi", bus_req, 1'b0);
        rd(OFF_CTRL, 32'h00000040, RESP_OKAY);
        rd(OFF_CH1_STAT, 32'h6, RESP_OKAY);
        wr(OFF_CTRL, 32'h000000C0, RESP_OKAY);
        settle(2);
        chk1("ch1 bus_req resumed", bus_req, 1'b1);
        rd(OFF_CH1_STAT, 32'h1, RESP_OKAY);
        wr(OFF_CTRL, 32'h00000040, RESP_OKAY);
        rd(OFF_CH1_STAT, 32'h2, RESP_OKAY);
        rd(OFF_CTRL, 32'h00000040, RESP_OKAY);
        wr(OFF_CTRL, 32'h000000C0, RESP_OKAY);
        @(posedge sys_clk);
        burst <= 1'b0;
        nmi <= 1'b1;
        @(posedge sys_clk);
        nmi <= 1'b0;
        settle(2);
        chk1("ch1 bus_req block nmi", bus_req, 1'b1);
        rd(OFF_CTRL, 32'h000000C0, RESP_OKAY);
        @(posedge sys_clk);
        ch1_req <= 1'b0;
        xfer_end <= 1'b1;
        @(posedge sys_clk);
        xfer_end <= 1'b0;
        settle(2);
        chk1("ch1 bus_req ended", bus_req, 1'b0);
        rd(OFF_IRQ_STAT, 32'h6, RESP_OKAY);
        wr(OFF_CTRL, 32'h00000040, RESP_OKAY);
        rd(OFF_CTRL, 32'h00000040, RESP_OKAY);
        chk1("ch1 xfer_en cleared", xfer_en, 1'b0);
        wr(OFF_IRQ_EN, 32'h2, RESP_OKAY);
        rd(OFF_IRQ_EN, 32'h2, RESP_OKAY);
        chk1("irq enabled", irq, 1'b1);
        wr(OFF_IRQ_EN, 32'h0, RESP_OKAY);
        settle(1);
        chk1("irq masked", irq, 1'b0);
        wr(OFF_IRQ_EN, 32'h2, RESP_OKAY);
        wr(OFF_IRQ_CLR, 32'h2, RESP_OKAY);
        settle(1);
        chk1("irq cleared", irq, 1'b0);
        rd(OFF_IRQ_STAT, 32'h4, RESP_OKAY);
        summarize();
    end
endmodule
`default_nettype wire
